// File: hw/psf_pkg.sv
// Package: register map, field layout and reset values of the paged status register bank
package psf_pkg;

    // ------------------------------------------------------------------
    // Register low addresses within a page
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_STEPPING = 8'h00;
    localparam logic [7:0] ADR_PAGE = 8'h01;
    localparam logic [7:0] ADR_PART_LO = 8'h02;
    localparam logic [7:0] ADR_PART_HI = 8'h03;
    localparam logic [7:0] ADR_SPEED = 8'h04;
    localparam logic [7:0] ADR_VERSION = 8'h05;
    localparam logic [7:0] ADR_THERMAL = 8'h09;
    localparam logic [7:0] ADR_HOUSING = 8'h0A;
    localparam logic [7:0] ADR_BUS_ADDR = 8'h0B;
    localparam logic [7:0] ADR_GEN_LIVE = 8'h0C;
    localparam logic [7:0] ADR_IN_LIVE = 8'h0D;
    localparam logic [7:0] ADR_LOCK_LIVE = 8'h0E;
    localparam logic [7:0] ADR_CAL_LIVE = 8'h0F;
    localparam logic [7:0] ADR_GEN_STKY = 8'h11;
    localparam logic [7:0] ADR_IN_STKY = 8'h12;
    localparam logic [7:0] ADR_LOCK_STKY = 8'h13;
    localparam logic [7:0] ADR_CAL_STKY = 8'h14;
    localparam logic [7:0] ADR_GEN_MASK = 8'h17;
    localparam logic [7:0] ADR_IN_MASK = 8'h18;
    localparam logic [7:0] ADR_LOCK_MASK = 8'h19;
    localparam logic [7:0] ADR_CAL_MASK = 8'h1A;
    localparam logic [7:0] ADR_READY = 8'hFE;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [7:0] READY_VAL = 8'h0F;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [5:0] BUS_ADDR_HI_RST = 6'h1A;
    localparam int NUM_INPUTS = 4;
    localparam int OFFREQ_BIT = 4;
    // Blank part defaults
    localparam logic BLANK_OUT_EN = 1'b0;
    localparam logic BLANK_IO_1V8 = 1'b1;
    localparam logic BLANK_REF_XO = 1'b1;

    typedef enum logic [1:0] {
        PSF_LOADING = 2'b00,
        PSF_READY = 2'b01,
        PSF_BURNING = 2'b11
    } psf_state_t;

    // Four live status groups
    typedef struct packed {
        logic [7:0] gen;
        logic [7:0] inp;
        logic [7:0] lock;
        logic [7:0] cal;
    } psf_stat_t;

    // Host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psf_req_t;

endpackage

// File: hw/psf_bank.sv
// Module: paged status, sticky flag and interrupt mask register bank
`timescale 1ns/1ps

module psf_bank #(
    parameter logic PREPROGRAMMED = 1'b0,
    parameter logic [7:0] STEPPING_ID = 8'h01,  // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h1234,  // Arbitrary value
    parameter logic [7:0] SPEED_CODE = 8'h00,  // Arbitrary value
    parameter logic [7:0] VERSION_CODE = 8'h00,  // Arbitrary value
    parameter logic [7:0] THERMAL_CODE = 8'h00,  // Arbitrary value
    parameter logic [7:0] HOUSING_CODE = 8'h00,  // Arbitrary value
    parameter int LOAD_CYCLES = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire psf_pkg::psf_req_t i_req,
    output logic [7:0] o_rdata,
    output logic [7:0] o_page,
    input wire psf_pkg::psf_stat_t i_live,
    input wire logic i_addr_strap_high,
    input wire logic i_addr_strap_low,
    input wire logic i_nvm_cfg_valid,
    input wire logic i_nvm_out_en,
    input wire logic i_nvm_io_1v8,
    input wire logic i_nvm_ref_xo,
    input wire logic i_burn_start,
    input wire logic i_burn_done,
    output logic o_burn_req,
    output logic o_out_en,
    output logic o_io_1v8,
    output logic o_ref_xo,
    output logic o_ready,
    output logic o_irq_out_n
);

    // ------------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------------
    logic [1:0] strap_meta_q;
    logic [1:0] strap_q;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_meta_q <= 2'h0;
            strap_q <= 2'h0;
        end else begin
            strap_meta_q <= {i_addr_strap_high, i_addr_strap_low};
            strap_q <= strap_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Power-up load and burn sequencing
    // ------------------------------------------------------------------
    psf_pkg::psf_state_t state_q;
    logic [15:0] load_cnt_q;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= psf_pkg::PSF_LOADING;
            load_cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                psf_pkg::PSF_LOADING: begin
                    load_cnt_q <= load_cnt_q + 16'h0001;
                    if (load_cnt_q >= 16'(LOAD_CYCLES - 1)) begin
                        state_q <= psf_pkg::PSF_READY;
                    end
                end
                psf_pkg::PSF_READY: begin
                    if (i_burn_start) begin
                        state_q <= psf_pkg::PSF_BURNING;
                    end
                end
                psf_pkg::PSF_BURNING: begin
                    if (i_burn_done) begin
                        state_q <= psf_pkg::PSF_READY;
                    end
                end
                default: begin
                    state_q <= psf_pkg::PSF_LOADING;
                end
            endcase
        end
    end
    assign o_ready = (state_q == psf_pkg::PSF_READY);
    assign o_burn_req = (state_q == psf_pkg::PSF_BURNING);

    // ------------------------------------------------------------------
    // Configuration defaults, loaded at end of power-up
    // ------------------------------------------------------------------
    logic load_done;
    assign load_done = (state_q == psf_pkg::PSF_LOADING) &&
        (load_cnt_q >= 16'(LOAD_CYCLES - 1));
    logic out_en_q;
    logic io_1v8_q;
    logic ref_xo_q;
    logic [5:0] bus_addr_hi_q;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_en_q <= psf_pkg::BLANK_OUT_EN;
            io_1v8_q <= psf_pkg::BLANK_IO_1V8;
            ref_xo_q <= psf_pkg::BLANK_REF_XO;
            bus_addr_hi_q <= psf_pkg::BUS_ADDR_HI_RST;
        end else if (load_done && PREPROGRAMMED && i_nvm_cfg_valid) begin
            out_en_q <= i_nvm_out_en;
            io_1v8_q <= i_nvm_io_1v8;
            ref_xo_q <= i_nvm_ref_xo;
        end
    end
    // Stored bus address has no write path; burn does not touch it
    assign o_out_en = out_en_q;
    assign o_io_1v8 = io_1v8_q;
    assign o_ref_xo = ref_xo_q;

    // ------------------------------------------------------------------
    // Page select
    // ------------------------------------------------------------------
    logic [7:0] page_q;
    logic wr_ok;
    assign wr_ok = i_req.wr && o_ready;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            page_q <= psf_pkg::PAGE_RST;
        end else if (wr_ok && i_req.addr == psf_pkg::ADR_PAGE) begin
            page_q <= i_req.wdata;
        end
    end
    assign o_page = page_q;
    logic page0;
    assign page0 = (page_q == 8'h00);

    // ------------------------------------------------------------------
    // Sticky flags and masks
    // ------------------------------------------------------------------
    logic [3:0][7:0] live;
    logic [3:0][7:0] stky_q;
    logic [3:0][7:0] mask_q;
    logic [3:0][7:0] adr_stky;
    logic [3:0][7:0] adr_mask;
    assign live = {i_live.cal, i_live.lock, i_live.inp, i_live.gen};
    assign adr_stky = {psf_pkg::ADR_CAL_STKY, psf_pkg::ADR_LOCK_STKY,
        psf_pkg::ADR_IN_STKY, psf_pkg::ADR_GEN_STKY};
    assign adr_mask = {psf_pkg::ADR_CAL_MASK, psf_pkg::ADR_LOCK_MASK,
        psf_pkg::ADR_IN_MASK, psf_pkg::ADR_GEN_MASK};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_grp
            logic sw;
            logic mw;
            assign sw = wr_ok && page0 && (i_req.addr == adr_stky[g]);
            assign mw = wr_ok && page0 && (i_req.addr == adr_mask[g]);
            always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    stky_q[g] <= 8'h00;
                end else if (sw) begin
                    // Live high wins; zero clears; one keeps
                    stky_q[g] <= live[g] | (stky_q[g] & i_req.wdata);
                end else begin
                    stky_q[g] <= stky_q[g] | live[g];
                end
            end
            always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    mask_q[g] <= psf_pkg::MASK_RST;
                end else if (mw) begin
                    mask_q[g] <= i_req.wdata;
                end
            end
            group_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
                live[g] != 8'h00 |=> (stky_q[g] & $past(live[g])) == $past(live[g]))
                else $error("sticky flag missed live bit");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    logic irq_n_q;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= ~(|(stky_q & ~mask_q));
        end
    end
    assign o_irq_out_n = irq_n_q;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rd_d;
    logic [7:0] rdata_q;
    always_comb begin
        rd_d = 8'h00;
        if (i_req.addr == psf_pkg::ADR_PAGE) begin
            rd_d = page_q;
        end else if (i_req.addr == psf_pkg::ADR_READY) begin
            rd_d = o_ready ? psf_pkg::READY_VAL : 8'h00;
        end else if (!page0) begin
            rd_d = 8'h00;
        end else if (i_req.addr == psf_pkg::ADR_STEPPING) begin
            rd_d = STEPPING_ID;
        end else if (i_req.addr == psf_pkg::ADR_PART_LO) begin
            rd_d = PART_CODE[7:0];
        end else if (i_req.addr == psf_pkg::ADR_PART_HI) begin
            rd_d = PART_CODE[15:8];
        end else if (i_req.addr == psf_pkg::ADR_SPEED) begin
            rd_d = SPEED_CODE;
        end else if (i_req.addr == psf_pkg::ADR_VERSION) begin
            rd_d = VERSION_CODE;
        end else if (i_req.addr == psf_pkg::ADR_THERMAL) begin
            rd_d = THERMAL_CODE;
        end else if (i_req.addr == psf_pkg::ADR_HOUSING) begin
            rd_d = HOUSING_CODE;
        end else if (i_req.addr == psf_pkg::ADR_BUS_ADDR) begin
            rd_d = {bus_addr_hi_q, strap_q};
        end else if (i_req.addr == psf_pkg::ADR_GEN_LIVE) begin
            rd_d = i_live.gen;
        end else if (i_req.addr == psf_pkg::ADR_IN_LIVE) begin
            rd_d = i_live.inp;
        end else if (i_req.addr == psf_pkg::ADR_LOCK_LIVE) begin
            rd_d = i_live.lock;
        end else if (i_req.addr == psf_pkg::ADR_CAL_LIVE) begin
            rd_d = i_live.cal;
        end else if (i_req.addr == psf_pkg::ADR_GEN_STKY) begin
            rd_d = stky_q[0];
        end else if (i_req.addr == psf_pkg::ADR_IN_STKY) begin
            rd_d = stky_q[1];
        end else if (i_req.addr == psf_pkg::ADR_LOCK_STKY) begin
            rd_d = stky_q[2];
        end else if (i_req.addr == psf_pkg::ADR_CAL_STKY) begin
            rd_d = stky_q[3];
        end else if (i_req.addr == psf_pkg::ADR_GEN_MASK) begin
            rd_d = mask_q[0];
        end else if (i_req.addr == psf_pkg::ADR_IN_MASK) begin
            rd_d = mask_q[1];
        end else if (i_req.addr == psf_pkg::ADR_LOCK_MASK) begin
            rd_d = mask_q[2];
        end else if (i_req.addr == psf_pkg::ADR_CAL_MASK) begin
            rd_d = mask_q[3];
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
        end else if (i_req.rd) begin
            rdata_q <= rd_d;
        end
    end
    assign o_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_zero_write(int k);
        wr_ok && page0 && i_req.addr == adr_stky[k] && i_req.wdata == 8'h00;
    endsequence
    sequence s_ones_write(int k);
        wr_ok && page0 && i_req.addr == adr_stky[k] && i_req.wdata == 8'hFF;
    endsequence
    sequence s_burn_start;
        o_ready && i_burn_start;
    endsequence
    sequence s_burn_end;
        o_burn_req && i_burn_done;
    endsequence
    sequence s_nvm_load;
        load_done && PREPROGRAMMED && i_nvm_cfg_valid;
    endsequence

    page_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        wr_ok && i_req.addr == psf_pkg::ADR_PAGE |=> page_q == $past(i_req.wdata))
        else $error("page select not updated");
    page_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !(wr_ok && i_req.addr == psf_pkg::ADR_PAGE) |=> $stable(page_q))
        else $error("page select changed without write");
    page_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && i_req.addr == psf_pkg::ADR_PAGE |=> o_rdata == $past(page_q))
        else $error("page read wrong");
    strap_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && page0 && i_req.addr == psf_pkg::ADR_BUS_ADDR
        |=> o_rdata[1:0] == $past(strap_q))
        else $error("strap bits wrong");
    bus_addr_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && page0 && i_req.addr == psf_pkg::ADR_BUS_ADDR
        |=> o_rdata[7:2] == psf_pkg::BUS_ADDR_HI_RST)
        else $error("stored bus address changed");
    input_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && page0 && i_req.addr == psf_pkg::ADR_IN_LIVE
        |=> o_rdata == $past(i_live.inp))
        else $error("input status read wrong");
    live_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && page0 && i_req.addr == psf_pkg::ADR_GEN_LIVE
        |=> o_rdata == $past(i_live.gen))
        else $error("general status read wrong");
    sticky_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_live.gen[0] |=> stky_q[0][0])
        else $error("sticky did not latch");
    sticky_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        stky_q[1] != 8'h00 && !(wr_ok && page0 && i_req.addr == psf_pkg::ADR_IN_STKY)
        |=> (stky_q[1] & $past(stky_q[1])) == $past(stky_q[1]))
        else $error("sticky lost without write");
    sticky_ones_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        s_ones_write(0) |=> stky_q[0] == ($past(stky_q[0]) | $past(i_live.gen)))
        else $error("writing ones changed sticky");
    sticky_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        s_zero_write(2) |=> stky_q[2] == $past(i_live.lock))
        else $error("sticky zero write wrong");
    cal_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && page0 && i_req.addr == psf_pkg::ADR_CAL_STKY
        |=> o_rdata == $past(stky_q[3]))
        else $error("calibration sticky read wrong");
    mask_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        wr_ok && page0 && i_req.addr == psf_pkg::ADR_IN_MASK
        |=> mask_q[1] == $past(i_req.wdata))
        else $error("mask not written");
    mask_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !(wr_ok && page0 && i_req.addr == psf_pkg::ADR_GEN_MASK) |=> $stable(mask_q[0]))
        else $error("mask changed without write");
    irq_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (stky_q[3] & ~mask_q[3]) != 8'h00 |=> !o_irq_out_n)
        else $error("interrupt not asserted");
    irq_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (stky_q & ~mask_q) == 32'h0 |=> o_irq_out_n)
        else $error("interrupt asserted without flag");
    ready_byte_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && o_ready && i_req.addr == psf_pkg::ADR_READY
        |=> o_rdata == psf_pkg::READY_VAL)
        else $error("ready byte wrong");
    ready_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.rd && !o_ready && i_req.addr == psf_pkg::ADR_READY |=> o_rdata == 8'h00)
        else $error("ready byte set too early");
    write_refused_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_req.wr && !o_ready |=> $stable(page_q) && $stable(mask_q))
        else $error("write taken while not ready");
    burn_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        s_burn_start |=> o_burn_req && !o_ready)
        else $error("burn did not start");
    burn_end_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        s_burn_end |=> o_ready && !o_burn_req)
        else $error("burn did not end");
    nvm_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        s_nvm_load |=> o_out_en == $past(i_nvm_out_en) && o_io_1v8 == $past(i_nvm_io_1v8)
        && o_ref_xo == $past(i_nvm_ref_xo))
        else $error("stored configuration not loaded");
    blank_default_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !PREPROGRAMMED |-> !o_out_en && o_io_1v8 && o_ref_xo)
        else $error("blank defaults wrong");

endmodule // psf_bank

// File: bench/psf_host.sv
// Host model issuing register reads and writes to the bank
`timescale 1ns/1ps
module psf_host (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    output psf_pkg::psf_req_t o_req
);
    // ------
    // Bus tasks
    // ------
    initial o_req = '{1'b0, 1'b0, 8'hC3, 8'h3C};
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_ref_clk);
        o_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{1'b0, 1'b1, a, ~a};
        @(posedge i_ref_clk);
        o_req <= '{1'b0, 1'b0, ~a, a};
        #1 d = i_rdata;
    endtask
    // Poll ready byte before writing
    task automatic poll_ready(output bit ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++) begin
            read(psf_pkg::ADR_READY, d);
            ok = (d === psf_pkg::READY_VAL);
        end
    endtask
endmodule  // psf_host

// File: bench/tb.sv
// Self-checking testbench of the paged status register bank
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] STEP = 8'h5C;  // Arbitrary value
    localparam logic [15:0] PART = 16'hC3A7;  // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    psf_pkg::psf_req_t req;
    psf_pkg::psf_stat_t live = '0;
    logic [7:0] rdata, page, rd, v, h;
    logic sh = 1'b0, sl = 1'b0, bstart = 1'b0, bdone = 1'b0;
    logic [3:0] nvm = 4'h5;
    logic burn_req, out_en, io_1v8, ref_xo, ready, irq_n;
    logic [2:0] pre_cfg;
    int fail_count = 0;
    int n_compared = 0;
    int g;
    bit ok;

    always #50 clk = ~clk;

    psf_bank #(.STEPPING_ID(STEP), .PART_CODE(PART), .LOAD_CYCLES(8)) i_dut (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .o_rdata(rdata),
        .o_page(page), .i_live(live), .i_addr_strap_high(sh),
        .i_addr_strap_low(sl), .i_nvm_cfg_valid(nvm[0]), .i_nvm_out_en(nvm[1]),
        .i_nvm_io_1v8(nvm[2]), .i_nvm_ref_xo(nvm[3]), .i_burn_start(bstart),
        .i_burn_done(bdone), .o_burn_req(burn_req), .o_out_en(out_en),
        .o_io_1v8(io_1v8), .o_ref_xo(ref_xo), .o_ready(ready), .o_irq_out_n(irq_n)
    );
    psf_bank #(.PREPROGRAMMED(1'b1), .LOAD_CYCLES(8)) i_dut_pre (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .o_rdata(),
        .o_page(), .i_live(live), .i_addr_strap_high(sh),
        .i_addr_strap_low(sl), .i_nvm_cfg_valid(nvm[0]), .i_nvm_out_en(nvm[1]),
        .i_nvm_io_1v8(nvm[2]), .i_nvm_ref_xo(nvm[3]), .i_burn_start(bstart),
        .i_burn_done(bdone), .o_burn_req(), .o_out_en(pre_cfg[2]),
        .o_io_1v8(pre_cfg[1]), .o_ref_xo(pre_cfg[0]), .o_ready(), .o_irq_out_n()
    );
    psf_host i_host (.i_ref_clk(clk), .i_rdata(rdata), .o_req(req));

    // ------
    // Helpers
    // ------
    function automatic psf_pkg::psf_stat_t grp(input int n, input logic [7:0] x);
        logic [31:0] s;
        s = '0;
        s[8*(3-n) +: 8] = x;
        return s;
    endfunction
    function automatic logic [7:0] exp_sticky(input logic [7:0] old,
        input logic [7:0] lv, input logic [7:0] wd);
        return lv | (old & wd);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compared=%0d failed=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    // ------
    // Main sequence
    // ------
    initial begin
        v = 8'($urandom(15374));
        nvm <= {3'($urandom), 1'b1};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({7'h0, out_en}, 8'h00);
        check({6'h0, io_1v8, ref_xo}, 8'h03);
        check({7'h0, irq_n}, 8'h01);
        i_host.read(psf_pkg::ADR_READY, rd);
        check(rd, 8'h00);
        i_host.poll_ready(ok);
        if (!ok) begin
            fail_count++;
            stop_test();
        end
        check({7'h0, ready}, 8'h01);
        check({5'h0, pre_cfg}, {5'h0, nvm[1], nvm[2], nvm[3]});
        i_host.write(psf_pkg::ADR_STEPPING, 8'h00);
        i_host.read(psf_pkg::ADR_STEPPING, rd);
        check(rd, STEP);
        i_host.read(psf_pkg::ADR_PART_LO, rd);
        check(rd, PART[7:0]);
        i_host.read(psf_pkg::ADR_PART_HI, rd);
        check(rd, PART[15:8]);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {sh, sl} <= 2'(k);
            repeat (3) @(posedge clk);
            i_host.write(psf_pkg::ADR_BUS_ADDR, 8'($urandom));
            i_host.read(psf_pkg::ADR_BUS_ADDR, rd);
            check(rd, {psf_pkg::BUS_ADDR_HI_RST, 2'(k)});
        end
        for (int r = 0; r < 3; r++) begin
            v = 8'($urandom_range(1, 255));
            i_host.write(psf_pkg::ADR_PAGE, v);
            i_host.read(psf_pkg::ADR_PAGE, rd);
            check(rd, v);
            check(page, v);
            i_host.read(psf_pkg::ADR_READY, rd);
            check(rd, psf_pkg::READY_VAL);
            i_host.read(psf_pkg::ADR_GEN_MASK, rd);
            check(rd, 8'h00);
        end
        i_host.write(psf_pkg::ADR_PAGE, 8'h00);
        for (int r = 0; r < 8; r++) begin
            g = r % 4;
            v = (r < 4) ? 8'hFF : 8'($urandom_range(1, 255));
            h = v & 8'($urandom);
            @(posedge clk);
            live <= grp(g, v);
            i_host.read(psf_pkg::ADR_GEN_LIVE + 8'(g), rd);
            check(rd, v);
            @(posedge clk);
            live <= grp(g, h);
            i_host.read(psf_pkg::ADR_GEN_STKY + 8'(g), rd);
            check(rd, v);
            check({7'h0, irq_n}, 8'h01);
            i_host.write(psf_pkg::ADR_GEN_MASK + 8'(g), ~v);
            i_host.read(psf_pkg::ADR_GEN_MASK + 8'(g), rd);
            check(rd, ~v);
            check({7'h0, irq_n}, 8'h00);
            i_host.write(psf_pkg::ADR_GEN_STKY + 8'(g), 8'hFF);
            i_host.read(psf_pkg::ADR_GEN_STKY + 8'(g), rd);
            check(rd, exp_sticky(v, h, 8'hFF));
            i_host.write(psf_pkg::ADR_GEN_STKY + 8'(g), 8'h00);
            i_host.read(psf_pkg::ADR_GEN_STKY + 8'(g), rd);
            check(rd, exp_sticky(v, h, 8'h00));
            @(posedge clk);
            live <= '0;
            i_host.write(psf_pkg::ADR_GEN_STKY + 8'(g), 8'h00);
            i_host.read(psf_pkg::ADR_GEN_STKY + 8'(g), rd);
            check(rd, 8'h00);
            check({7'h0, irq_n}, 8'h01);
            i_host.write(psf_pkg::ADR_GEN_MASK + 8'(g), 8'hFF);
        end
        @(posedge clk);
        bstart <= 1'b1;
        @(posedge clk);
        bstart <= 1'b0;
        #1;
        check({7'h0, burn_req}, 8'h01);
        i_host.write(psf_pkg::ADR_PAGE, 8'h07);
        i_host.read(psf_pkg::ADR_PAGE, rd);
        check(rd, 8'h00);
        @(posedge clk);
        bdone <= 1'b1;
        @(posedge clk);
        bdone <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({7'h0, burn_req}, 8'h00);
        i_host.read(psf_pkg::ADR_BUS_ADDR, rd);
        check(rd, {psf_pkg::BUS_ADDR_HI_RST, 2'h3});
        stop_test();
    end
endmodule  // tb
